// [include/scsi_ctl_map.svh]
/*
 * constants for the scsi chip host controller: chip port numbers,
 * chip register bit positions, own register offsets, timing figures.
 * assumes a 125 MHz system clock; included by bare name.
 */
`ifndef SCSI_CTL_MAP_SVH
`define SCSI_CTL_MAP_SVH

// ---------------------------------------------------------------
// chip ports (three address pins)
// ---------------------------------------------------------------
`define PORT_DATA        3'h0
`define PORT_MODE        3'h2
`define PORT_BUS_STAT    3'h4
`define PORT_BUS_AND_ST  3'h5
`define PORT_SEND        3'h5
`define PORT_TGT_RX      3'h6
`define PORT_INIT_RX     3'h7
`define PORT_CLEAR       3'h7

// ---------------------------------------------------------------
// chip register bits
// ---------------------------------------------------------------
`define MODE_ARB_BIT     0
`define MODE_DMA_BIT     1
`define MODE_TGT_BIT     6
`define MODE_CFG_MASK    8'h3C
`define BUSST_REQ_BIT    5
`define BAS_ACK_BIT      0

// ---------------------------------------------------------------
// own register file
// ---------------------------------------------------------------
`define REG_CMD          4'h0
`define REG_MODE_CFG     4'h1
`define REG_STATUS       4'h2
`define REG_RDATA        4'h3
`define CMD_SEND         4'h1
`define CMD_TGT_RX       4'h2
`define CMD_INIT_RX      4'h3
`define CMD_CLEAR        4'h4
`define CMD_ARB          4'h5
`define CMD_RESET        4'h6
`define CMD_EOP          4'h7
`define CMD_DRAIN        4'h8
`define STAT_BUSY_BIT    0
`define STAT_IRQ_BIT     1
`define STAT_DRAIN_BIT   2
`define MODE_CFG_RESET   8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS    8
`define ACC_NS           120
`define EOP_MIN_NS       100
`define RST_MIN_NS       200
`define ARB_WAIT_NS      2200
`define CEIL_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC          `CEIL_CYC(`ACC_NS)
`define EOP_CYC          `CEIL_CYC(`EOP_MIN_NS)
`define RST_CYC          `CEIL_CYC(`RST_MIN_NS)
`define ARB_WAIT_CYC     `CEIL_CYC(`ARB_WAIT_NS)

`endif

// [include/scsi_ctl_pkg.sv]
/*
 * types of the scsi chip host controller: state encodings.
 * assumes nothing beyond a sv compiler.
 */
package scsi_ctl_pkg;

   // ------------------------------------------------------------
   // sequencer and bus cycle states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [10:0] {
      ST_IDLE    = 11'h001,
      ST_MODE    = 11'h002,
      ST_START   = 11'h004,
      ST_CLEAR   = 11'h008,
      ST_ARB     = 11'h010,
      ST_ARBWAIT = 11'h020,
      ST_ARBRD   = 11'h040,
      ST_RESET   = 11'h080,
      ST_EOP     = 11'h100,
      ST_POLLREQ = 11'h200,
      ST_POLLACK = 11'h400
   } ctl_state_e;

   typedef enum logic [3:0] {
      CY_IDLE   = 4'h1,
      CY_SETUP  = 4'h2,
      CY_STROBE = 4'h4,
      CY_HOLD   = 4'h8
   } cyc_state_e;

endpackage

// [hdl/chip_bus_cycle.sv]
/*
 * one chip access: register read/write with chip select, or a dma
 * write cycle with acknowledge and optional end-of-process strobe.
 * assumes go_i is a one-cycle pulse given only while idle.
 */
`include "scsi_ctl_map.svh"

module chip_bus_cycle (
   input wire logic ref_clk_i, // system clock
   input wire logic arst_n_i, // async reset, low
   input wire logic go_i, // start one access
   input wire logic write_i, // write, else read
   input wire logic dma_i, // acknowledge instead of select
   input wire logic eop_i, // end-of-process with strobe
   input wire logic [2:0] addr_i, // chip port
   input wire logic [7:0] wdata_i, // write byte
   input wire logic [7:0] chip_d_i, // chip data pins in
   output logic chip_cs_n_o, // chip select
   output logic dack_n_o, // dma acknowledge
   output logic eop_n_o, // transfer_end_strobe
   output logic rd_n_o, // read strobe
   output logic wr_n_o, // write strobe
   output logic [2:0] addr_o, // address pins
   output logic [7:0] d_o, // data pins out
   output logic d_oe_o, // data pins driven
   output logic [7:0] rdata_o, // byte read
   output logic done_o // access finished, pulse
);
   import scsi_ctl_pkg::*;

   cyc_state_e state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [7:0] d_meta_r, d_sync_r;
   logic wr_r, dma_r, eop_r;
   logic take, acc_nxt, strb_nxt, wr_nxt, dma_nxt, eop_nxt;

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   assign take = (state_r == CY_IDLE) && go_i;
   assign wr_nxt = take ? write_i : wr_r;
   assign dma_nxt = take ? dma_i : dma_r;
   assign eop_nxt = take ? eop_i : eop_r;
   assign acc_nxt = (state_nxt != CY_IDLE);
   assign strb_nxt = (state_nxt == CY_STROBE);

   // strobe width fixed by counter, long enough for the eop minimum
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         CY_IDLE: if (go_i) state_nxt = CY_SETUP;
         CY_SETUP: begin
            state_nxt = CY_STROBE;
            cnt_nxt = 8'(`ACC_CYC - 1);
         end
         CY_STROBE: begin
            if (cnt_r == 8'h00) state_nxt = CY_HOLD;
            else cnt_nxt = cnt_r - 8'h01;
         end
         CY_HOLD: state_nxt = CY_IDLE;
         default: state_nxt = CY_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= CY_IDLE;
         cnt_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // latched request, feeds the address and data pins directly
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_r <= 1'b0;
         dma_r <= 1'b0;
         eop_r <= 1'b0;
         addr_o <= 3'h0;
         d_o <= 8'h00;
      end else if (take) begin
         wr_r <= write_i;
         dma_r <= dma_i;
         eop_r <= eop_i;
         addr_o <= addr_i;
         d_o <= wdata_i;
      end
   end

   // pin strobes registered from next state, so no glitches
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chip_cs_n_o <= 1'b1;
         dack_n_o <= 1'b1;
         eop_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         d_oe_o <= 1'b0;
      end else begin
         chip_cs_n_o <= !(acc_nxt && !dma_nxt);
         dack_n_o <= !(acc_nxt && dma_nxt);
         eop_n_o <= !(strb_nxt && eop_nxt);
         rd_n_o <= !(strb_nxt && !wr_nxt);
         wr_n_o <= !(strb_nxt && wr_nxt);
         d_oe_o <= acc_nxt && wr_nxt;
      end
   end

   // data pins are asynchronous: two flops before capture
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         d_meta_r <= 8'h00;
         d_sync_r <= 8'h00;
         rdata_o <= 8'h00;
         done_o <= 1'b0;
      end else begin
         d_meta_r <= chip_d_i;
         d_sync_r <= d_meta_r;
         if (state_r == CY_STROBE && cnt_r == 8'h00 && !wr_r)
            rdata_o <= d_sync_r;
         done_o <= (state_r == CY_HOLD);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic [7:0] lo_cnt_r;
   logic strb_lo;
   localparam int ACC_MIN = `ACC_CYC;
   assign strb_lo = !rd_n_o || !wr_n_o;

   // helper: length of the current strobe
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) lo_cnt_r <= 8'h00;
      else if (strb_lo) lo_cnt_r <= lo_cnt_r + 8'h01;
      else lo_cnt_r <= 8'h00;
   end

   property p_strobe_len;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         $fell(strb_lo) |-> ($past(lo_cnt_r) == 8'(ACC_MIN - 1));
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe width differs from access count");

   property p_eop_qual;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         $fell(eop_n_o) |->
            (!eop_n_o && !dack_n_o && (!wr_n_o || !rd_n_o))[*8];
   endproperty
   a_eop_qual: assert property (p_eop_qual)
      else $error("eop not held with dack and strobe");

endmodule // chip_bus_cycle

// [hdl/scsi_host_ctl.sv]
/*
 * host controller for a clockless scsi interface chip: starts dma
 * transfers, clears chip flags, runs arbitration, resets the chip,
 * ends dma with an end-of-process strobe and waits for the bus to
 * drain. assumes the chip pins are asynchronous and software uses a
 * plain strobe port with read data one cycle later.
 */
`include "scsi_ctl_map.svh"

module scsi_host_ctl (
   input wire logic ref_clk_i, // 125 MHz clock
   input wire logic arst_n_i, // async reset, low
   input wire logic [3:0] sw_addr_i, // register address
   input wire logic [7:0] sw_wdata_i, // register write data
   input wire logic sw_wr_i, // write strobe
   input wire logic sw_rd_i, // read strobe
   output logic [7:0] sw_rdata_o, // read data, next cycle
   input wire logic [7:0] chip_d_i, // chip data pins in
   output logic [7:0] chip_d_o, // chip data pins out
   output logic chip_d_oe_o, // chip data driven
   output logic [2:0] chip_addr_o, // chip address pins
   output logic chip_cs_n_o, // chip select
   output logic chip_rd_n_o, // chip read strobe
   output logic chip_wr_n_o, // chip write strobe
   output logic chip_rst_n_o, // chip reset
   output logic dack_n_o, // dma acknowledge
   output logic transfer_end_strobe_n_o, // end of process
   input wire logic irq_i // chip interrupt, high
);
   import scsi_ctl_pkg::*;

   ctl_state_e state_r, state_nxt;
   logic [15:0] timer_r, timer_nxt;
   logic [7:0] mode_cfg_r, rdata_r, cyc_rdata, cyc_wdata;
   logic [2:0] start_port_r, cyc_addr;
   logic role_r, req_seen_r, drain_ok_r, go_r, cyc_done;
   logic irq_meta_r, irq_sync_r;
   logic cmd_take, cyc_write, cyc_dma, is_access, go_nxt, drained;
   logic [3:0] cmd;
   logic [7:0] mode_start, mode_arb, status_val, rd_val;

   // ------------------------------------------------------------
   // software port decode
   // ------------------------------------------------------------
   assign cmd = sw_wdata_i[3:0];
   assign cmd_take = sw_wr_i && (sw_addr_i == `REG_CMD)
      && (state_r == ST_IDLE);
   assign status_val = {5'h00, drain_ok_r, irq_sync_r,
      (state_r != ST_IDLE)};
   assign rd_val = (sw_addr_i == `REG_MODE_CFG) ? mode_cfg_r :
      (sw_addr_i == `REG_STATUS) ? status_val :
      (sw_addr_i == `REG_RDATA) ? rdata_r : 8'h00;

   // mode bytes: software options plus dma enable and role, or plus the arbitrate bit
   assign mode_start = (mode_cfg_r & `MODE_CFG_MASK)
      | (8'h01 << `MODE_DMA_BIT)
      | ({7'h00, role_r} << `MODE_TGT_BIT);
   assign mode_arb = (mode_cfg_r & `MODE_CFG_MASK)
      | (8'h01 << `MODE_ARB_BIT);

   // ------------------------------------------------------------
   // access selection per state
   // ------------------------------------------------------------
   assign is_access = (state_nxt != ST_IDLE) && (state_nxt != ST_ARBWAIT)
      && (state_nxt != ST_RESET);
   assign go_nxt = is_access && (state_nxt != state_r);
   assign cyc_write = (state_r == ST_MODE) || (state_r == ST_START)
      || (state_r == ST_ARB) || (state_r == ST_EOP);
   assign cyc_dma = (state_r == ST_EOP);
   assign cyc_addr = (state_r == ST_MODE) ? `PORT_MODE :
      (state_r == ST_ARB) ? `PORT_MODE :
      (state_r == ST_START) ? start_port_r :
      (state_r == ST_CLEAR) ? `PORT_CLEAR :
      (state_r == ST_POLLREQ) ? `PORT_BUS_STAT :
      (state_r == ST_POLLACK) ? `PORT_BUS_AND_ST : `PORT_DATA;
   assign cyc_wdata = (state_r == ST_MODE) ? mode_start :
      (state_r == ST_ARB) ? mode_arb : 8'h00; // start data is ignored
   assign drained = !req_seen_r && !cyc_rdata[`BAS_ACK_BIT];

   // sequencer; drain polling has no timeout, only a drained poll or the async reset ends it
   always_comb begin
      state_nxt = state_r;
      timer_nxt = (timer_r != 16'h0000) ? timer_r - 16'h0001 : timer_r;
      case (state_r)
         ST_IDLE: begin
            if (cmd_take) begin
               case (cmd)
                  `CMD_SEND, `CMD_TGT_RX, `CMD_INIT_RX: state_nxt = ST_MODE;
                  `CMD_CLEAR: state_nxt = ST_CLEAR;
                  `CMD_ARB: state_nxt = ST_ARB;
                  `CMD_RESET: begin
                     state_nxt = ST_RESET;
                     timer_nxt = 16'(`RST_CYC - 1);
                  end
                  `CMD_EOP: state_nxt = ST_EOP;
                  `CMD_DRAIN: state_nxt = ST_POLLREQ;
                  default: state_nxt = ST_IDLE;
               endcase
            end
         end
         ST_MODE: if (cyc_done) state_nxt = ST_START;
         ST_START: if (cyc_done) state_nxt = ST_IDLE;
         ST_CLEAR: if (cyc_done) state_nxt = ST_IDLE;
         ST_ARB: begin
            if (cyc_done) begin
               state_nxt = ST_ARBWAIT;
               timer_nxt = 16'(`ARB_WAIT_CYC - 1);
            end
         end
         ST_ARBWAIT: if (timer_r == 16'h0000) state_nxt = ST_ARBRD;
         ST_ARBRD: if (cyc_done) state_nxt = ST_IDLE;
         ST_RESET: if (timer_r == 16'h0000) state_nxt = ST_IDLE;
         ST_EOP: if (cyc_done) state_nxt = ST_IDLE;
         ST_POLLREQ: if (cyc_done) state_nxt = ST_POLLACK;
         ST_POLLACK: begin
            if (cyc_done) state_nxt = drained ? ST_IDLE : ST_POLLREQ;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         timer_r <= 16'h0000;
         go_r <= 1'b0;
         chip_rst_n_o <= 1'b1;
      end else begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         go_r <= go_nxt;
         chip_rst_n_o <= (state_nxt != ST_RESET);
      end
   end

   // ------------------------------------------------------------
   // own registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_cfg_r <= `MODE_CFG_RESET;
         start_port_r <= `PORT_SEND;
         role_r <= 1'b0;
         sw_rdata_o <= 8'h00;
      end else begin
         if (sw_wr_i && sw_addr_i == `REG_MODE_CFG) mode_cfg_r <= sw_wdata_i;
         if (cmd_take) begin
            start_port_r <= (cmd == `CMD_TGT_RX) ? `PORT_TGT_RX :
               (cmd == `CMD_INIT_RX) ? `PORT_INIT_RX : `PORT_SEND;
            role_r <= (cmd == `CMD_TGT_RX) ? 1'b1 :
               (cmd == `CMD_INIT_RX) ? 1'b0 : mode_cfg_r[`MODE_TGT_BIT];
         end
         sw_rdata_o <= sw_rd_i ? rd_val : 8'h00;
      end
   end

   // read results and drain flag; a new command clears the flag
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= 8'h00;
         req_seen_r <= 1'b0;
         drain_ok_r <= 1'b0;
      end else begin
         if (cyc_done && !cyc_write) rdata_r <= cyc_rdata;
         if (cyc_done && state_r == ST_POLLREQ)
            req_seen_r <= cyc_rdata[`BUSST_REQ_BIT];
         if (state_r == ST_POLLACK && cyc_done && drained)
            drain_ok_r <= 1'b1;
         else if (cmd_take) drain_ok_r <= 1'b0;
      end
   end

   // interrupt pin is asynchronous: two flops before use
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_meta_r <= 1'b0;
         irq_sync_r <= 1'b0;
      end else begin
         irq_meta_r <= irq_i;
         irq_sync_r <= irq_meta_r;
      end
   end

   chip_bus_cycle u_cycle (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .go_i(go_r),
      .write_i(cyc_write),
      .dma_i(cyc_dma),
      .eop_i(cyc_dma),
      .addr_i(cyc_addr),
      .wdata_i(cyc_wdata),
      .chip_d_i(chip_d_i),
      .chip_cs_n_o(chip_cs_n_o),
      .dack_n_o(dack_n_o),
      .eop_n_o(transfer_end_strobe_n_o),
      .rd_n_o(chip_rd_n_o),
      .wr_n_o(chip_wr_n_o),
      .addr_o(chip_addr_o),
      .d_o(chip_d_o),
      .d_oe_o(chip_d_oe_o),
      .rdata_o(cyc_rdata),
      .done_o(cyc_done)
   );

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic [7:0] last_mode_r;
   logic [15:0] arb_cnt_r;
   logic [7:0] rst_lo_r;
   logic mode_wr;
   localparam int ARB_MIN = `ARB_WAIT_CYC;
   localparam int RST_MIN = `RST_CYC;
   assign mode_wr = !chip_cs_n_o && !chip_wr_n_o
      && chip_addr_o == `PORT_MODE;

   // helpers: last mode byte, time since arbitrate, reset length
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_mode_r <= 8'h00;
         arb_cnt_r <= 16'h0000;
         rst_lo_r <= 8'h00;
      end else begin
         if (mode_wr) last_mode_r <= chip_d_o;
         if (mode_wr && chip_d_o[`MODE_ARB_BIT]) arb_cnt_r <= 16'h0000;
         else if (arb_cnt_r != 16'hFFFF) arb_cnt_r <= arb_cnt_r + 16'h0001;
         rst_lo_r <= chip_rst_n_o ? 8'h00 : rst_lo_r + 8'h01;
      end
   end

   property p_send_mode;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         (!chip_wr_n_o && !chip_cs_n_o && chip_addr_o == `PORT_SEND)
            |-> last_mode_r[`MODE_DMA_BIT];
   endproperty
   a_send_mode: assert property (p_send_mode)
      else $error("send start without dma enable");

   property p_trx_mode;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         (!chip_wr_n_o && !chip_cs_n_o && chip_addr_o == `PORT_TGT_RX)
            |-> (last_mode_r[`MODE_DMA_BIT] && last_mode_r[`MODE_TGT_BIT]);
   endproperty
   a_trx_mode: assert property (p_trx_mode)
      else $error("target receive start with wrong mode");

   property p_irx_mode;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         (!chip_wr_n_o && !chip_cs_n_o && chip_addr_o == `PORT_INIT_RX)
            |-> (last_mode_r[`MODE_DMA_BIT] && !last_mode_r[`MODE_TGT_BIT]);
   endproperty
   a_irx_mode: assert property (p_irx_mode)
      else $error("initiator receive start with wrong mode");

   property p_clear_read;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         (cmd_take && cmd == `CMD_CLEAR) |-> ##[2:20]
            (!chip_cs_n_o && !chip_rd_n_o && chip_addr_o == `PORT_CLEAR);
   endproperty
   a_clear_read: assert property (p_clear_read)
      else $error("clear command gave no port 7 read");

   property p_arb_wait;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         (state_r == ST_ARBRD && !chip_rd_n_o) |-> (arb_cnt_r >= ARB_MIN);
   endproperty
   a_arb_wait: assert property (p_arb_wait)
      else $error("data bus read too soon after arbitration");

   property p_rst_len;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         $rose(chip_rst_n_o) |-> (rst_lo_r >= RST_MIN);
   endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("chip reset pulse too short");

   property p_drain;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
         $rose(drain_ok_r) |->
            (!$past(req_seen_r) && !$past(cyc_rdata[`BAS_ACK_BIT]));
   endproperty
   a_drain: assert property (p_drain)
      else $error("drain reported with req or ack still set");

   c_send: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !chip_wr_n_o && !chip_cs_n_o && chip_addr_o == `PORT_SEND);
   c_arb: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      state_r == ST_ARBRD && cyc_done);
   c_eop: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $fell(transfer_end_strobe_n_o));
   c_drain: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(drain_ok_r));

endmodule // scsi_host_ctl

// [sim/scsi_chip_model.sv]
/* behavioural chip on the far side of the host controller.
   assumes active-low strobes and a bus that is free, except that
   the first req poll finds req set. */
module scsi_chip_model #(parameter logic [7:0] OWN_ID = 8'h40) (
   input wire logic cs_n_i, // select
   input wire logic rd_n_i, // read strobe
   input wire logic wr_n_i, // write strobe
   input wire logic rst_n_i, // chip reset
   input wire logic dack_n_i, // dma acknowledge
   input wire logic eop_n_i, // transfer_end_strobe
   input wire logic [2:0] addr_i, // port
   input wire logic [7:0] d_i, // data in
   input wire logic oe_i, // host drives data
   output logic [7:0] d_o = 0, // data out
   output logic irq_o = 0 // interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mode = 0;
   logic [2:0] start_port = 0;
   int n4 = 0;
   logic [7:0] start_mode = 0;
   time t_arb = 0, t_dat = 0, t_rst = 0, rst_len = 0, t_e = 0;
   wire eop_act = !eop_n_i && !dack_n_i && (!wr_n_i || !rd_n_i);
   // a reset pulse too short leaves the latch alone
   always @(rst_n_i) if (!rst_n_i) t_rst = $time; else begin
      rst_len = $time - t_rst;
      if (rst_len >= 200) irq_o = 0;
      if (rst_len >= 200) mode = 0;
   end
   // register writes land at the strobe's trailing edge
   always @(posedge wr_n_i) if (!cs_n_i && oe_i) begin
      if (addr_i == 3'h2) mode = d_i;
      if (addr_i == 3'h2 && d_i[0]) t_arb = $time;
      if (addr_i >= 3'h5) begin
         start_port = addr_i;
         start_mode = mode;
      end
   end
   // released data shows the inverse so stale bytes never pass
   // a host driving the pins during a read gets no byte back
   always @(rd_n_i) if (!rd_n_i && !cs_n_i && !oe_i) begin
      d_o = (addr_i == 3'h0) ? OWN_ID :
         (addr_i == 3'h4 && n4 == 0) ? 8'h20 : 8'h00;
      if (addr_i == 3'h4) n4++;
      if (addr_i == 3'h0) t_dat = $time;
      if (addr_i == 3'h7) irq_o = 0;
   end else if (rd_n_i) d_o = ~d_o;
   // end strobe counts only when qualified long enough
   always @(eop_act) if (eop_act) t_e = $time;
   else if ($time - t_e >= 100 && mode[1] && mode[3])
      irq_o = 1;
endmodule // scsi_chip_model

// [sim/testbench.sv]
/* self-checking bench: host controller against a chip model.
   assumes the own register map of the controller's map header. */
`include "scsi_ctl_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0, arst_n_i = 0, sw_wr_i = 0, sw_rd_i = 0;
   logic [3:0] sw_addr_i = 0;
   logic [7:0] sw_wdata_i = 0, sw_rdata_o, chip_d_i, chip_d_o, rd_v;
   logic [2:0] a;
   logic oe, cs_n, rd_n, wr_n, rst_n, dack_n, eop_n, irq;
   int err_count = 0, num_checks = 0;
   wire [2:0] m_port = u_scsi_chip_model.start_port;
   wire [7:0] m_mode = u_scsi_chip_model.start_mode;
   wire arb_ok = u_scsi_chip_model.t_dat - u_scsi_chip_model.t_arb >= 2200;
   always #4 ref_clk_i = ~ref_clk_i;
   scsi_host_ctl u_scsi_host_ctl (.ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
      .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
      .chip_d_i(chip_d_i), .chip_d_o(chip_d_o), .chip_d_oe_o(oe),
      .chip_addr_o(a), .chip_cs_n_o(cs_n), .chip_rd_n_o(rd_n),
      .chip_wr_n_o(wr_n), .chip_rst_n_o(rst_n), .dack_n_o(dack_n),
      .transfer_end_strobe_n_o(eop_n), .irq_i(irq));
   scsi_chip_model u_scsi_chip_model (.cs_n_i(cs_n), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .rst_n_i(rst_n), .dack_n_i(dack_n), .eop_n_i(eop_n),
      .addr_i(a), .d_i(chip_d_o), .oe_i(oe), .d_o(chip_d_i), .irq_o(irq));
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // software port cycles, one-cycle strobes
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge ref_clk_i);
      sw_addr_i <= ad;
      sw_wdata_i <= d;
      sw_wr_i <= 1;
      @(posedge ref_clk_i);
      sw_wr_i <= 0;
   endtask
   task automatic rd(input logic [3:0] ad);
      @(posedge ref_clk_i);
      sw_addr_i <= ad;
      sw_rd_i <= 1;
      @(posedge ref_clk_i);
      sw_rd_i <= 0;
      #1 rd_v = sw_rdata_o;
   endtask
   task automatic rdchk(input logic [3:0] ad, input logic [7:0] m, e,
                        input string nm);
      rd(ad);
      chk(nm, e, rd_v & m);
   endtask
   // issue a command and poll busy under a bound
   task automatic cmd(input logic [3:0] c);
      wr(`REG_CMD, {4'h0, c});
      repeat (2) @(posedge ref_clk_i);
      for (int i = 0; i < 600; i++) begin
         rd(`REG_STATUS);
         if (rd_v[`STAT_BUSY_BIT] === 1'b0) return;
      end
      err_count++;
      $display("mismatch busy exp 0 got 1");
      end_of_test;
   endtask
   // role bit forced by receive starts, taken from config by send
   task automatic t_starts;
      for (int i = 1; i <= 3; i++) begin
         wr(`REG_MODE_CFG, (i == 2) ? 8'h00 : 8'h40);
         cmd(i[3:0]);
         chk("port", 8'(4 + i), {5'h0, m_port});
         chk("mode", (i == 3) ? 8'h02 : 8'h42, m_mode);
      end
   endtask
   // raise by end strobe, clear by port read, then by chip reset
   task automatic t_irq;
      wr(`REG_MODE_CFG, 8'h08);
      cmd(`CMD_SEND);
      cmd(`CMD_EOP);
      rdchk(`REG_STATUS, 8'h02, 8'h02, "irq");
      cmd(`CMD_CLEAR);
      rdchk(`REG_STATUS, 8'h02, 8'h00, "irq");
      cmd(`CMD_EOP);
      cmd(`CMD_RESET);
      chk("rst", 8'h01, {7'h0, u_scsi_chip_model.rst_len >= 200});
      rdchk(`REG_STATUS, 8'h02, 8'h00, "irq");
   endtask
   // arbitration wait, then the id on the data bus
   task automatic t_arb;
      cmd(`CMD_ARB);
      chk("arb", 8'h01, {7'h0, arb_ok});
      rdchk(`REG_RDATA, 8'hFF, 8'h40, "id");
   endtask
   // req seen on the first poll forces a second round before done
   task automatic t_drain;
      cmd(`CMD_DRAIN);
      chk("polls", 8'h02, 8'(u_scsi_chip_model.n4));
      rdchk(`REG_STATUS, 8'h04, 8'h04, "drain");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1;
      rdchk(`REG_MODE_CFG, 8'hFF, `MODE_CFG_RESET, "mode_cfg");
      rdchk(4'hF, 8'hFF, 8'h00, "unmapped");
      t_starts();
      t_irq();
      t_arb();
      t_drain();
      end_of_test;
   end
endmodule // testbench
